// *** inc/acc_regs.svh ***
// Purpose: register offsets, gain limit, record level mask and reset values
// Assumes: 7-bit register addresses on the control port
// Notes:   definitions only
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH
`define ACC_OFS_PB_CTRL    7'h64
`define ACC_OFS_PB_CLK     7'h65
`define ACC_OFS_PB_ZCFG    7'h66
`define ACC_OFS_PB_PIN     7'h67
`define ACC_OFS_PB_LVOL    7'h68
`define ACC_OFS_PB_RVOL    7'h69
`define ACC_OFS_PB_LPEAK   7'h6A
`define ACC_OFS_PB_RPEAK   7'h6B
`define ACC_OFS_REC_LGAIN  7'h6C
`define ACC_OFS_REC_RGAIN  7'h6D
`define ACC_OFS_REC_CTRL   7'h6E
`define ACC_OFS_REC_CLK    7'h6F
`define ACC_OFS_REC_LVOL   7'h70
`define ACC_RST_REG        8'h00
`define ACC_RST_VOL        8'hFF
`define ACC_GAIN_MAX       6'h30
`define ACC_ADC_VOL_MASK   8'h7F
`endif

// *** inc/acc_pkg.sv ***
// Purpose: shared types for the converter control block
// Assumes: nothing
// Notes:   codes follow the register field encodings
package acc_pkg;
  typedef enum logic [1:0] {ROUTE_NORMAL, ROUTE_RIGHT, ROUTE_LEFT,
                            ROUTE_SWAP} acc_route_t;
  typedef enum logic [1:0] {PIN_RZERO, PIN_LZERO, PIN_EITHER,
                            PIN_BOTH} acc_pinsel_t;
endpackage : acc_pkg

// *** hw/acc_control_regs.sv ***
// Purpose: playback and record converter control and status registers
// Assumes: byte-wide register port from the serial control decoder
// Notes:   analog effects appear as control outputs
// Operation
// - digital reset holds playback logic, keeps registers
// - hard reset powers down, outputs to ground
// - routing field selects left/right source per channel
// - polarity field inverts left and/or right
// - independent left and right playback mute
// - de-emphasis none, 44.1, 32, 48 kHz
// - silence zero flag unless disabled
// - zero-data zero flag unless disabled
// - polarity bit sets zero flag active level
// - shared pin: left zero or interrupt
// - right pin: right, left, either, both zero while shared pin carries interrupt, else right zero
// - playback volume 0.375 dB steps, all-ones 0 dB
// - peak level six bits, 1 dB steps
// - input gain 0.5 dB steps, clamp at +24
// - modulator clock master by 2 or 4
// - high-pass filter inserted when enabled
// - five independent power-down controls
// - independent left and right record mute
// - record master divider 1, 2, 3, 1
// - linear record gain, all-ones unity
`include "acc_regs.svh"
`timescale 1ns/10ps
module acc_control_regs
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // register port
  input  wire logic        regWrite,
  input  wire logic [6:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  output logic      [7:0]  regRdData,
  // playback status from datapath, same clock
  input  wire logic        leftDataZero,
  input  wire logic        rightDataZero,
  input  wire logic [5:0]  playback_left_peak_level,
  input  wire logic [5:0]  playback_right_peak_level,
  input  wire logic        irqRequest,
  // playback controls
  output logic             playbackDigitalReset,
  output logic             playbackPowerDown,
  output logic             leftFromRight,
  output logic             rightFromLeft,
  output logic             leftInvert,
  output logic             rightInvert,
  output logic             playbackLeftMute,
  output logic             playbackRightMute,
  output logic      [1:0]  deemphasis_select,
  output logic      [1:0]  playback_clock_divider,
  output logic      [1:0]  interpolation_ratio,
  output logic      [7:0]  playback_left_level,
  output logic      [7:0]  playback_right_level,
  // pins
  output logic             left_zero_or_irq_pin,
  output logic             right_zero_pin,
  // record controls
  output logic      [5:0]  left_input_gain,
  output logic      [5:0]  right_input_gain,
  output logic             modulator_clock_select,
  output logic             highpass_enable,
  output logic             record_converter_off,
  output logic             record_analog_off,
  output logic             recordRightMute,
  output logic             recordLeftMute,
  output logic             left_amp_off,
  output logic             right_amp_off,
  output logic             reference_buffer_off,
  output logic      [1:0]  record_clock_divider,
  output logic      [7:0]  record_left_level
);

  logic [7:0] pbCtrl;
  logic [7:0] pbClk;
  logic [7:0] pbZcfg;
  logic [7:0] pbPin;
  logic [7:0] pbLvol;
  logic [7:0] pbRvol;
  logic [7:0] recLgain;
  logic [7:0] recRgain;
  logic [7:0] recCtrl;
  logic [7:0] recClk;
  logic [7:0] recLvol;

  // address decode
  wire wrPbCtrl  = regWrite && regAddr == `ACC_OFS_PB_CTRL;
  wire wrPbClk   = regWrite && regAddr == `ACC_OFS_PB_CLK;
  wire wrPbZcfg  = regWrite && regAddr == `ACC_OFS_PB_ZCFG;
  wire wrPbPin   = regWrite && regAddr == `ACC_OFS_PB_PIN;
  wire wrPbLvol  = regWrite && regAddr == `ACC_OFS_PB_LVOL;
  wire wrPbRvol  = regWrite && regAddr == `ACC_OFS_PB_RVOL;
  wire wrRecLg   = regWrite && regAddr == `ACC_OFS_REC_LGAIN;
  wire wrRecRg   = regWrite && regAddr == `ACC_OFS_REC_RGAIN;
  wire wrRecCtrl = regWrite && regAddr == `ACC_OFS_REC_CTRL;
  wire wrRecClk  = regWrite && regAddr == `ACC_OFS_REC_CLK;
  wire wrRecLvol = regWrite && regAddr == `ACC_OFS_REC_LVOL;

  // reserved bits masked
  // stored bits beyond defined fields are dropped so they read as zero, except record level bit 7, which is stored and read back
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      pbCtrl   <= `ACC_RST_REG;
      pbClk    <= `ACC_RST_REG;
      pbZcfg   <= `ACC_RST_REG;
      pbPin    <= `ACC_RST_REG;
      pbLvol   <= `ACC_RST_VOL;
      pbRvol   <= `ACC_RST_VOL;
      recLgain <= `ACC_RST_REG;
      recRgain <= `ACC_RST_REG;
      recCtrl  <= `ACC_RST_REG;
      recClk   <= `ACC_RST_REG;
      recLvol  <= `ACC_RST_VOL;
    end
    else
    begin
      if (wrPbCtrl)  pbCtrl   <= regWrData;
      if (wrPbClk)   pbClk    <= regWrData & 8'h3F;
      if (wrPbZcfg)  pbZcfg   <= regWrData & 8'h07;
      if (wrPbPin)   pbPin    <= regWrData & 8'h70;
      if (wrPbLvol)  pbLvol   <= regWrData;
      if (wrPbRvol)  pbRvol   <= regWrData;
      if (wrRecLg)   recLgain <= regWrData & 8'h3F;
      if (wrRecRg)   recRgain <= regWrData & 8'h3F;
      if (wrRecCtrl) recCtrl  <= regWrData;
      if (wrRecClk)  recClk   <= regWrData & 8'h13;
      if (wrRecLvol) recLvol  <= regWrData;
    end
  end

  // field decode
  wire hardReset   = pbCtrl[7];
  wire digReset    = pbCtrl[6];
  acc_pkg::acc_route_t route;
  assign route = acc_pkg::acc_route_t'(pbCtrl[5:4]);
  wire silenceOff  = pbZcfg[2];
  wire dataZeroOff = pbZcfg[1];
  wire flagLow     = pbZcfg[0];
  wire pinIrq      = pbPin[6];
  acc_pkg::acc_pinsel_t pinSel;
  assign pinSel = acc_pkg::acc_pinsel_t'(pbPin[5:4]);

  wire next_leftFromRight = route == acc_pkg::ROUTE_RIGHT ||
                            route == acc_pkg::ROUTE_SWAP;
  wire next_rightFromLeft = route == acc_pkg::ROUTE_LEFT ||
                            route == acc_pkg::ROUTE_SWAP;

  // silence flag source
  // mute or zero volume counts as silence for each channel
  wire leftSilent  = !silenceOff && (pbCtrl[0] || pbLvol == 8'h00);
  wire rightSilent = !silenceOff && (pbCtrl[1] || pbRvol == 8'h00);
  wire leftZero  = leftSilent  || (!dataZeroOff && leftDataZero);
  wire rightZero = rightSilent || (!dataZeroOff && rightDataZero);

  // right pin function
  // selector only applies while the shared pin carries the interrupt
  wire rightPinZero =
    !pinIrq                      ? rightZero :
    pinSel == acc_pkg::PIN_RZERO ? rightZero :
    pinSel == acc_pkg::PIN_LZERO ? leftZero  :
    pinSel == acc_pkg::PIN_EITHER ? (leftZero || rightZero) :
                                   (leftZero && rightZero);
  wire leftPinAsserted = pinIrq ? irqRequest : leftZero;
  // flag polarity
  // interrupt is a flag too, so it follows the same polarity
  wire next_leftPin  = leftPinAsserted ^ flagLow;
  wire next_rightPin = rightPinZero ^ flagLow;

  wire [5:0] lGainClamped = recLgain[5:0] >= `ACC_GAIN_MAX ?
                            `ACC_GAIN_MAX : recLgain[5:0];
  wire [5:0] rGainClamped = recRgain[5:0] >= `ACC_GAIN_MAX ?
                            `ACC_GAIN_MAX : recRgain[5:0];

  // read mux
  wire [7:0] next_regRdData =
    regAddr == `ACC_OFS_PB_CTRL   ? pbCtrl :
    regAddr == `ACC_OFS_PB_CLK    ? pbClk :
    regAddr == `ACC_OFS_PB_ZCFG   ? pbZcfg :
    regAddr == `ACC_OFS_PB_PIN    ? pbPin :
    regAddr == `ACC_OFS_PB_LVOL   ? pbLvol :
    regAddr == `ACC_OFS_PB_RVOL   ? pbRvol :
    regAddr == `ACC_OFS_PB_LPEAK  ? {2'h0, playback_left_peak_level} :
    regAddr == `ACC_OFS_PB_RPEAK  ? {2'h0, playback_right_peak_level} :
    regAddr == `ACC_OFS_REC_LGAIN ? recLgain :
    regAddr == `ACC_OFS_REC_RGAIN ? recRgain :
    regAddr == `ACC_OFS_REC_CTRL  ? recCtrl :
    regAddr == `ACC_OFS_REC_CLK   ? recClk :
    regAddr == `ACC_OFS_REC_LVOL  ? recLvol : 8'h00;

  // registered outputs
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      regRdData            <= 8'h00;
      playbackDigitalReset <= 1'b0;
      playbackPowerDown    <= 1'b0;
      leftFromRight        <= 1'b0;
      rightFromLeft        <= 1'b0;
      leftInvert           <= 1'b0;
      rightInvert          <= 1'b0;
      playbackLeftMute     <= 1'b0;
      playbackRightMute    <= 1'b0;
      deemphasis_select    <= 2'h0;
      playback_clock_divider <= 2'h0;
      interpolation_ratio  <= 2'h0;
      playback_left_level  <= `ACC_RST_VOL;
      playback_right_level <= `ACC_RST_VOL;
      left_zero_or_irq_pin <= 1'b0;
      right_zero_pin       <= 1'b0;
    end
    else
    begin
      regRdData            <= next_regRdData;
      playbackDigitalReset <= digReset;
      playbackPowerDown    <= hardReset;
      leftFromRight        <= next_leftFromRight;
      rightFromLeft        <= next_rightFromLeft;
      leftInvert           <= pbCtrl[2];
      rightInvert          <= pbCtrl[3];
      playbackLeftMute     <= pbCtrl[0];
      playbackRightMute    <= pbCtrl[1];
      deemphasis_select    <= pbClk[1:0];
      playback_clock_divider <= pbClk[5:4];
      interpolation_ratio  <= pbClk[3:2];
      playback_left_level  <= pbLvol;
      playback_right_level <= pbRvol;
      left_zero_or_irq_pin <= next_leftPin;
      right_zero_pin       <= next_rightPin;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      left_input_gain        <= 6'h00;
      right_input_gain       <= 6'h00;
      modulator_clock_select <= 1'b0;
      highpass_enable        <= 1'b0;
      record_converter_off   <= 1'b0;
      record_analog_off      <= 1'b0;
      recordRightMute        <= 1'b0;
      recordLeftMute         <= 1'b0;
      left_amp_off           <= 1'b0;
      right_amp_off          <= 1'b0;
      reference_buffer_off   <= 1'b0;
      record_clock_divider   <= 2'h0;
      record_left_level      <= `ACC_RST_VOL & `ACC_ADC_VOL_MASK;
    end
    else
    begin
      left_input_gain        <= lGainClamped;
      right_input_gain       <= rGainClamped;
      modulator_clock_select <= recCtrl[7];
      highpass_enable        <= recCtrl[6];
      record_converter_off   <= recCtrl[5];
      record_analog_off      <= recCtrl[4];
      left_amp_off           <= recCtrl[1];
      right_amp_off          <= recCtrl[0];
      reference_buffer_off   <= recClk[4];
      recordRightMute        <= recCtrl[3];
      recordLeftMute         <= recCtrl[2];
      // divider, code 3 acts as 1
      record_clock_divider   <= recClk[1:0] == 2'h3 ? 2'h0 : recClk[1:0];
      record_left_level      <= recLvol & `ACC_ADC_VOL_MASK;
    end
  end

endmodule : acc_control_regs

// *** test/acc_control_regs_asserts.sv ***
// Purpose: port checks for the converter control registers
// Assumes: a write shows at the outputs two edges later
// Notes:   bound from the bench top
`timescale 1ns/10ps
module acc_control_regs_asserts
(
  // clock, reset, register port
  input wire logic       clk_sys,
  input wire logic       nrst,
  input wire logic       regWrite,
  input wire logic [6:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  // watched status and controls
  input wire logic [5:0] playback_left_peak_level,
  input wire logic       playbackDigitalReset,
  input wire logic       playbackPowerDown,
  input wire logic       leftFromRight,
  input wire logic       rightFromLeft,
  input wire logic       leftInvert,
  input wire logic       playbackLeftMute,
  input wire logic [5:0] left_input_gain,
  input wire logic       highpass_enable,
  input wire logic       recordLeftMute,
  input wire logic       reference_buffer_off,
  input wire logic [1:0] record_clock_divider,
  input wire logic [7:0] record_left_level,
  // remaining controls
  input wire logic       rightInvert,
  input wire logic       playbackRightMute,
  input wire logic [5:0] right_input_gain,
  input wire logic       modulator_clock_select,
  input wire logic       record_converter_off,
  input wire logic       record_analog_off,
  input wire logic       recordRightMute,
  input wire logic       left_amp_off,
  input wire logic       right_amp_off
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  wire logic wrPb = regWrite && regAddr == 7'h64;
  wire logic wrGain = regWrite && regAddr == 7'h6C;
  wire logic wrRec = regWrite && regAddr == 7'h6E;
  wire logic wrRclk = regWrite && regAddr == 7'h6F;
  wire logic wrRvol = regWrite && regAddr == 7'h70;
  wire logic wrRgain = regWrite && regAddr == 7'h6D;
  chk_right_ctl:
    assert property (wrPb |-> ##2 {rightInvert, playbackRightMute}
      == $past({regWrData[3], regWrData[1]}, 2))
      else $error("right playback control wrong");
  chk_rec_power:
    assert property (wrRec |-> ##2 {modulator_clock_select,
      record_converter_off, record_analog_off, recordRightMute,
      left_amp_off, right_amp_off} == $past({regWrData[7], regWrData[5],
      regWrData[4], regWrData[3], regWrData[1], regWrData[0]}, 2))
      else $error("record power control wrong");
  chk_right_gain:
    assert property (wrRgain |-> ##2 right_input_gain
      == ($past(regWrData[5:0], 2) > 6'h30 ? 6'h30 : $past(regWrData[5:0], 2)))
      else $error("right gain clamp wrong");
  chk_reset_bits:
    assert property (wrPb |-> ##2 {playbackPowerDown, playbackDigitalReset}
      == $past(regWrData[7:6], 2)) else $error("reset bits wrong");
  chk_route_sel:
    assert property (wrPb |-> ##2 {rightFromLeft, leftFromRight}
      == $past(regWrData[5:4], 2)) else $error("routing wrong");
  chk_left_invert:
    assert property (wrPb |-> ##2 leftInvert == $past(regWrData[2], 2))
      else $error("left inversion wrong");
  chk_mute_left:
    assert property (wrPb |-> ##2 playbackLeftMute == $past(regWrData[0], 2))
      else $error("left mute wrong");
  chk_peak_read:
    assert property (regAddr == 7'h6A |=> regRdData
      == {2'h0, $past(playback_left_peak_level)}) else $error("peak wrong");
  chk_gain_clamp:
    assert property (wrGain |-> ##2 left_input_gain
      == ($past(regWrData[5:0], 2) > 6'h30 ? 6'h30 : $past(regWrData[5:0], 2)))
      else $error("gain clamp wrong");
  chk_filter_mute:
    assert property (wrRec |-> ##2 {highpass_enable, recordLeftMute}
      == $past({regWrData[6], regWrData[2]}, 2)) else $error("record ctl wrong");
  chk_clk_div:
    assert property (wrRclk |-> ##2 reference_buffer_off == $past(regWrData[4], 2)
      && record_clock_divider == (&$past(regWrData[1:0], 2) ? 2'h0
      : $past(regWrData[1:0], 2))) else $error("record divider wrong");
  chk_rec_level:
    assert property (wrRvol |-> ##2 record_left_level
      == {1'h0, $past(regWrData[6:0], 2)}) else $error("record level wrong");
endmodule : acc_control_regs_asserts

// *** test/acc_control_regs_tb_top.sv ***
// Purpose: self-checking bench for the converter control registers
// Assumes: outputs settle two edges after a write
// Notes:   pin rows, register rows, then hand tests
`timescale 1ns/10ps
module acc_control_regs_tb_top;
  logic       clk_sys = 1'h0;
  logic       nrst = 1'h0;
  logic       regWrite = 1'h0;
  logic [6:0] regAddr = 7'h00;
  logic [7:0] regWrData = 8'h00;
  logic       leftDataZero = 1'h0;
  logic       rightDataZero = 1'h0;
  logic       irqRequest = 1'h0;
  logic [5:0] playback_left_peak_level = 6'h2A;
  logic [5:0] playback_right_peak_level = 6'h15;
  logic [7:0] regRdData, playback_left_level, playback_right_level;
  logic [7:0] record_left_level, rdVal;
  logic [5:0] left_input_gain;
  logic [1:0] deemphasis_select, playback_clock_divider, interpolation_ratio;
  logic       leftFromRight, rightFromLeft, playbackDigitalReset;
  logic       left_zero_or_irq_pin, right_zero_pin;
  int         fail_count = 0;
  int         checks = 0;
  // nibbles: ctrl, zero cfg, pin sel, {ldz,rdz,irq}, {left,right} pins
  logic [19:0] pinRows [12] = '{20'h00042, 20'h01041, 20'h02040, 20'h10002,
    20'h14000, 20'h20413, 20'h00541, 20'h00621, 20'h00720, 20'h00761,
    20'h01411, 20'h00031};
  // address, write data, readback
  logic [22:0] regRows [14] = '{{7'h64, 8'hA5, 8'hA5}, {7'h65, 8'hFF, 8'h3F},
    {7'h66, 8'hFF, 8'h07}, {7'h67, 8'hFF, 8'h70}, {7'h68, 8'h00, 8'h00},
    {7'h69, 8'h7E, 8'h7E}, {7'h6A, 8'h55, 8'h2A}, {7'h6B, 8'h55, 8'h15},
    {7'h6C, 8'hFF, 8'h3F}, {7'h6D, 8'h2F, 8'h2F}, {7'h6E, 8'hC3, 8'hC3},
    {7'h6F, 8'hFF, 8'h13}, {7'h70, 8'h40, 8'h40}, {7'h71, 8'hAA, 8'h00}};
  acc_control_regs dut_u
  (
    .clk_sys, .nrst, .regWrite, .regAddr, .regWrData, .regRdData,
    .leftDataZero, .rightDataZero, .playback_left_peak_level,
    .playback_right_peak_level, .irqRequest, .playbackDigitalReset,
    .playbackPowerDown(), .leftFromRight, .rightFromLeft, .leftInvert(),
    .rightInvert(), .playbackLeftMute(), .playbackRightMute(),
    .deemphasis_select, .playback_clock_divider, .interpolation_ratio,
    .playback_left_level, .playback_right_level, .left_zero_or_irq_pin,
    .right_zero_pin, .left_input_gain, .right_input_gain(),
    .modulator_clock_select(), .highpass_enable(), .record_converter_off(),
    .record_analog_off(), .recordRightMute(), .recordLeftMute(),
    .left_amp_off(), .right_amp_off(), .reference_buffer_off(),
    .record_clock_divider(), .record_left_level
  );
  always #12.5 clk_sys = ~clk_sys;
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #2;
    regWrite = 1'h1;
    regAddr = a;
    regWrData = d;
    @(posedge clk_sys);
    #2;
    regWrite = 1'h0;
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    #2;
    regAddr = a;
    @(posedge clk_sys);
    #2;
    d = regRdData;
  endtask : rd
  task automatic settle();
    repeat (2) @(posedge clk_sys);
    #2;
  endtask : settle
  task automatic end_of_test();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  // reset held 16 cycles, then volumes at full scale
  task automatic reset_check();
    nrst = 1'h0;
    repeat (16) @(posedge clk_sys);
    #2;
    nrst = 1'h1;
    settle();
    cmp(playback_right_level, 8'hFF);
    cmp(record_left_level, 8'h7F);
    rd(7'h70, rdVal);
    cmp(rdVal, 8'hFF);
  endtask : reset_check
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    end_of_test();
  end
  initial
  begin
    reset_check();
    foreach (pinRows[i])
    begin
      wr(7'h64, {4'h0, pinRows[i][19:16]});
      wr(7'h66, {4'h0, pinRows[i][15:12]});
      wr(7'h67, {pinRows[i][11:8], 4'h0});
      {leftDataZero, rightDataZero, irqRequest} = pinRows[i][6:4];
      settle();
      cmp({left_zero_or_irq_pin, right_zero_pin}, pinRows[i][1:0]);
    end
    wr(7'h68, 8'h00);
    settle();
    cmp(left_zero_or_irq_pin, 1'h1);
    foreach (regRows[i])
    begin
      wr(regRows[i][22:16], regRows[i][15:8]);
      rd(regRows[i][22:16], rdVal);
      cmp(rdVal, regRows[i][7:0]);
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(7'h64, 8'(i << 4));
      wr(7'h65, 8'(i * 21));
      settle();
      cmp({rightFromLeft, leftFromRight}, 8'(i));
      cmp({playback_clock_divider, interpolation_ratio, deemphasis_select},
          8'(i * 21));
    end
    // boundary just above the gain ceiling
    wr(7'h6C, 8'h31);
    settle();
    cmp(left_input_gain, 8'h30);
    wr(7'h68, 8'h12);
    wr(7'h64, 8'h40);
    settle();
    cmp(playbackDigitalReset, 1'h1);
    rd(7'h68, rdVal);
    cmp(rdVal, 8'h12);
    reset_check();
    end_of_test();
  end
endmodule : acc_control_regs_tb_top
bind acc_control_regs acc_control_regs_asserts chk_u (.clk_sys, .nrst,
  .regWrite, .regAddr, .regWrData, .regRdData, .playback_left_peak_level,
  .playbackDigitalReset, .playbackPowerDown, .leftFromRight, .rightFromLeft,
  .leftInvert, .playbackLeftMute, .left_input_gain, .highpass_enable,
  .recordLeftMute, .reference_buffer_off, .record_clock_divider,
  .record_left_level, .rightInvert, .playbackRightMute, .right_input_gain,
  .modulator_clock_select, .record_converter_off, .record_analog_off,
  .recordRightMute, .left_amp_off, .right_amp_off);
